// file: cpmc_pkg.sv
// package: register map, field layout and types for clock path mode config
package cpmc_pkg;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [9:0] CPMC_OFS_PLL_MODE = 10'h010;
	localparam logic [9:0] CPMC_OFS_VCO_CAL = 10'h018;
	localparam logic [9:0] CPMC_OFS_REF_EN = 10'h01C;
	localparam logic [9:0] CPMC_OFS_VCO_DIV = 10'h1E0;
	localparam logic [9:0] CPMC_OFS_DIST_SRC = 10'h1E1;
	localparam logic [9:0] CPMC_OFS_UPDATE = 10'h232;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CPMC_POS_PLL_MODE = 0;
	localparam int CPMC_POS_CP_MODE = 2;
	localparam int CPMC_POS_PFD_POL = 7;
	localparam int CPMC_POS_CAL = 0;
	localparam int CPMC_POS_BYPASS = 0;
	localparam int CPMC_POS_SRC_VCO = 1;
	localparam int CPMC_POS_UPDATE = 0;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] CPMC_RST_PLL_MODE = 8'h01;
	localparam logic [7:0] CPMC_RST_VCO_CAL = 8'h00;
	localparam logic [7:0] CPMC_RST_REF_EN = 8'h00;
	localparam logic [7:0] CPMC_RST_VCO_DIV = 8'h00;
	localparam logic [7:0] CPMC_RST_DIST_SRC = 8'h00;

	// ----------------------------------------
	// encodings
	// ----------------------------------------
	localparam logic [1:0] CPMC_PLL_NORMAL = 2'h0;
	localparam logic [1:0] CPMC_PLL_ASYNC_PD = 2'h1;

	typedef enum logic [1:0] {
		CPMC_CP_HIGH_Z = 2'h0,
		CPMC_CP_PUMP_UP = 2'h1,
		CPMC_CP_PUMP_DOWN = 2'h2,
		CPMC_CP_NORMAL = 2'h3
	} cpmc_cp_mode_t;

	// one image of all stored registers
	typedef struct packed {
		logic [7:0] pll_mode_control;
		logic [7:0] vco_calibration_control;
		logic [7:0] reference_input_enable;
		logic [7:0] vco_divider_ratio;
		logic [7:0] distribution_source_select;
	} cpmc_regs_t;

	localparam cpmc_regs_t CPMC_REGS_RST = '{
		pll_mode_control: CPMC_RST_PLL_MODE,
		vco_calibration_control: CPMC_RST_VCO_CAL,
		reference_input_enable: CPMC_RST_REF_EN,
		vco_divider_ratio: CPMC_RST_VCO_DIV,
		distribution_source_select: CPMC_RST_DIST_SRC
	};

	// decoded clock path controls
	typedef struct packed {
		logic pll_on;
		logic pll_power_down;
		logic src_vco;
		logic src_ext_clk;
		logic div_bypass;
		logic pfd_negative;
		cpmc_cp_mode_t cp_mode;
		logic [2:0] vco_div_sel;
		logic [2:0] ref_enable;
	} cpmc_path_t;

endpackage

// file: cpmc_cal_seq.sv
// module: vco calibration start sequencer on the update strobe
`timescale 1ns/1ps
module cpmc_cal_seq
	import cpmc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// control
	input wire logic update,
	input wire logic cal_staged,
	// status
	output logic cal_start,
	output logic cal_armed
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {
		CPMC_CAL_IDLE = 2'b01,
		CPMC_CAL_ARMED = 2'b10
	} cpmc_cal_st_t;

	cpmc_cal_st_t st_r;
	cpmc_cal_st_t st_nxt;
	logic start_r;
	logic start_nxt;

	// a start needs the staged bit 1 at an update strobe while idle, and a strobe must see it 0 to leave armed, so a held 1 cannot retrigger
	always_comb begin
		st_nxt = st_r;
		start_nxt = 1'b0;
		case (st_r)
			CPMC_CAL_IDLE: begin
				if (update && cal_staged) begin
					st_nxt = CPMC_CAL_ARMED;
					start_nxt = 1'b1;
				end
			end
			CPMC_CAL_ARMED: begin
				if (update && !cal_staged) begin
					st_nxt = CPMC_CAL_IDLE;
				end
			end
			default: begin
				st_nxt = CPMC_CAL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= CPMC_CAL_IDLE;
			start_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			start_r <= start_nxt;
		end
	end

	assign cal_start = start_r;
	// one-hot: bit 1 is the armed flop, so busy leaves as a bare flop
	assign cal_armed = st_r[1];

endmodule

// file: cpmc_top.sv
// module: clock path mode configuration registers and decode
// Operation
// - pll mode 00 normal, 01 async power-down
// - source bit 1 vco, 0 external clock
// - bypass bit 0 uses divider, 1 bypasses
// - polarity bit 0 positive, 1 negative
// - update strobe with cal bit set starts calibration, once until a strobe sees the bit clear
// - charge pump has four two-bit modes
// - reset: pll off, divide two, external clock
`timescale 1ns/1ps
module cpmc_top
	import cpmc_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// clock path controls
	output cpmc_path_t path,
	output logic cal_start,
	output logic cal_busy
);

	// ----------------------------------------
	// staging and active images
	// ----------------------------------------
	cpmc_regs_t stage_r;
	cpmc_regs_t stage_nxt;
	cpmc_regs_t act_r;
	cpmc_regs_t act_nxt;
	logic update;

	assign update = reg_wr && (reg_addr == CPMC_OFS_UPDATE[ADDR_W-1:0])
		&& reg_wdata[CPMC_POS_UPDATE];

	always_comb begin
		stage_nxt = stage_r;
		if (reg_wr) begin
			case (reg_addr)
				CPMC_OFS_PLL_MODE[ADDR_W-1:0]: begin
					stage_nxt.pll_mode_control = reg_wdata;
				end
				CPMC_OFS_VCO_CAL[ADDR_W-1:0]: begin
					stage_nxt.vco_calibration_control = reg_wdata;
				end
				CPMC_OFS_REF_EN[ADDR_W-1:0]: begin
					stage_nxt.reference_input_enable = reg_wdata;
				end
				CPMC_OFS_VCO_DIV[ADDR_W-1:0]: begin
					stage_nxt.vco_divider_ratio = reg_wdata;
				end
				CPMC_OFS_DIST_SRC[ADDR_W-1:0]: begin
					stage_nxt.distribution_source_select = reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// update strobe copies the staged image into the active one
	always_comb begin
		act_nxt = act_r;
		if (update) begin
			act_nxt = stage_r;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage_r <= CPMC_REGS_RST;
			act_r <= CPMC_REGS_RST;
		end else begin
			stage_r <= stage_nxt;
			act_r <= act_nxt;
		end
	end

	// ----------------------------------------
	// read-back: staged values, update reads zero
	// ----------------------------------------
	logic [7:0] rdata_nxt;
	logic [7:0] rdata_r;
	logic rvalid_r;

	always_comb begin
		rdata_nxt = 8'h00;
		case (reg_addr)
			CPMC_OFS_PLL_MODE[ADDR_W-1:0]: begin
				rdata_nxt = stage_r.pll_mode_control;
			end
			CPMC_OFS_VCO_CAL[ADDR_W-1:0]: begin
				rdata_nxt = stage_r.vco_calibration_control;
			end
			CPMC_OFS_REF_EN[ADDR_W-1:0]: begin
				rdata_nxt = stage_r.reference_input_enable;
			end
			CPMC_OFS_VCO_DIV[ADDR_W-1:0]: begin
				rdata_nxt = stage_r.vco_divider_ratio;
			end
			CPMC_OFS_DIST_SRC[ADDR_W-1:0]: begin
				rdata_nxt = stage_r.distribution_source_select;
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
		if (!reg_rd) begin
			rdata_nxt = rdata_r;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rvalid_r <= reg_rd;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;

	// ----------------------------------------
	// path decode from the active image
	// ----------------------------------------
	cpmc_path_t path_nxt;
	cpmc_path_t path_r;
	logic [1:0] pll_fld;
	logic [1:0] cp_fld;

	assign pll_fld = act_nxt.pll_mode_control[CPMC_POS_PLL_MODE +: 2];
	assign cp_fld = act_nxt.pll_mode_control[CPMC_POS_CP_MODE +: 2];

	always_comb begin
		path_nxt = '0;
		// other mode codes are treated as power-down, the safe state
		path_nxt.pll_on = (pll_fld == CPMC_PLL_NORMAL);
		path_nxt.pll_power_down = !path_nxt.pll_on;
		path_nxt.src_vco =
			act_nxt.distribution_source_select[CPMC_POS_SRC_VCO];
		path_nxt.src_ext_clk = !path_nxt.src_vco;
		path_nxt.div_bypass =
			act_nxt.distribution_source_select[CPMC_POS_BYPASS];
		path_nxt.pfd_negative =
			act_nxt.pll_mode_control[CPMC_POS_PFD_POL];
		path_nxt.cp_mode = cpmc_cp_mode_t'(cp_fld);
		path_nxt.vco_div_sel = act_nxt.vco_divider_ratio[2:0];
		path_nxt.ref_enable = act_nxt.reference_input_enable[2:0];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			path_r <= '{pll_on: 1'b0, pll_power_down: 1'b1, src_vco: 1'b0,
				src_ext_clk: 1'b1, div_bypass: 1'b0, pfd_negative: 1'b0,
				cp_mode: CPMC_CP_HIGH_Z, vco_div_sel: 3'h0,
				ref_enable: 3'h0};
		end else begin
			path_r <= path_nxt;
		end
	end

	assign path = path_r;

	// ----------------------------------------
	// calibration start
	// ----------------------------------------
	logic cal_start_w;
	logic cal_armed_w;

	cpmc_cal_seq cpmc_cal_seq_inst (
		.clock(clock),
		.rst_n(rst_n),
		.update(update),
		.cal_staged(stage_r.vco_calibration_control[CPMC_POS_CAL]),
		.cal_start(cal_start_w),
		.cal_armed(cal_armed_w)
	);

	assign cal_start = cal_start_w;
	assign cal_busy = cal_armed_w;

endmodule

// file: cpmc_chk.sv
// checker: port-level assertions for clock path mode config
`timescale 1ns/1ps
module cpmc_chk
	import cpmc_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// controls
	input wire cpmc_path_t path,
	input wire logic cal_start,
	input wire logic cal_busy
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic upd;
	logic wr_mode;
	logic wr_src;
	assign upd = reg_wr && reg_addr == CPMC_OFS_UPDATE[ADDR_W-1:0]
		&& reg_wdata[CPMC_POS_UPDATE];
	assign wr_mode = reg_wr && reg_addr == CPMC_OFS_PLL_MODE[ADDR_W-1:0];
	assign wr_src = reg_wr && reg_addr == CPMC_OFS_DIST_SRC[ADDR_W-1:0];
	// ----------------------------------------
	// shadow of staged fields, rebuilt from the bus
	// ----------------------------------------
	logic [1:0] mode_shd;
	logic pol_shd;
	logic vco_shd;
	logic byp_shd;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_shd <= CPMC_RST_PLL_MODE[CPMC_POS_PLL_MODE +: 2];
			pol_shd <= CPMC_RST_PLL_MODE[CPMC_POS_PFD_POL];
			vco_shd <= CPMC_RST_DIST_SRC[CPMC_POS_SRC_VCO];
			byp_shd <= CPMC_RST_DIST_SRC[CPMC_POS_BYPASS];
		end else begin
			if (wr_mode) begin
				mode_shd <= reg_wdata[CPMC_POS_PLL_MODE +: 2];
				pol_shd <= reg_wdata[CPMC_POS_PFD_POL];
			end
			if (wr_src) begin
				vco_shd <= reg_wdata[CPMC_POS_SRC_VCO];
				byp_shd <= reg_wdata[CPMC_POS_BYPASS];
			end
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_pll; path.pll_on != path.pll_power_down; endproperty
	a_pll: assert property (p_pll) else $error("pll on and off");
	property p_src; path.src_vco != path.src_ext_clk; endproperty
	a_src: assert property (p_src) else $error("two sources");
	// stray writes must never reach the active controls
	property p_hold; !upd |=> $stable(path); endproperty
	a_hold: assert property (p_hold) else $error("path moved");
	property p_cal1; cal_start |=> !cal_start; endproperty
	a_cal1: assert property (p_cal1) else $error("long start");
	property p_cal2; cal_start |-> cal_busy; endproperty
	a_cal2: assert property (p_cal2) else $error("start idle");
	property p_cal3; !upd |=> !cal_start; endproperty
	a_cal3: assert property (p_cal3) else $error("stray start");
	property p_busy; cal_busy && !upd |=> cal_busy; endproperty
	a_busy: assert property (p_busy) else $error("busy lost");
	property p_rd; reg_rd |=> reg_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("no read answer");
	// decode checked against what the bus staged before the strobe
	property p_mode;
		upd |=> path.pll_on == ($past(mode_shd) == CPMC_PLL_NORMAL);
	endproperty
	a_mode: assert property (p_mode) else $error("mode decode");
	property p_pol; upd |=> path.pfd_negative == $past(pol_shd); endproperty
	a_pol: assert property (p_pol) else $error("polarity");
	property p_vsel; upd |=> path.src_vco == $past(vco_shd); endproperty
	a_vsel: assert property (p_vsel) else $error("source select");
	property p_byp; upd |=> path.div_bypass == $past(byp_shd); endproperty
	a_byp: assert property (p_byp) else $error("divider bypass");
	c_cal: cover property (cal_start);
	c_vco: cover property (path.pll_on && path.src_vco);
	c_byp: cover property (path.div_bypass);
	c_ext: cover property (path.src_ext_clk && path.div_bypass);
endmodule
bind cpmc_top cpmc_chk #(.ADDR_W(ADDR_W)) cpmc_chk_inst (.clock, .rst_n,
	.reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
	.path, .cal_start, .cal_busy);

// file: testbench.sv
// testbench: register sequences for clock path mode config
`timescale 1ns/1ps
module testbench;
	import cpmc_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [9:0] reg_addr = 10'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic reg_rvalid, cal_start, cal_busy;
	logic [1:0] m;
	cpmc_path_t path;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	cpmc_top cpmc_top_inst (.clock, .rst_n, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .reg_rvalid, .path, .cal_start, .cal_busy);
	initial begin
		forever #50 clock = ~clock;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h %h", $time, seen, exp);
		end
	endtask
	// strobe dropped a full cycle later, so calls never collide
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk(16'(reg_rvalid), 16'h0001);
		chk(16'(reg_rdata), 16'(e));
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			print_verdict;
		end
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		#1;
		chk(16'(path), 16'h1400);
		rd(CPMC_OFS_PLL_MODE, 8'h01);
		rd(CPMC_OFS_DIST_SRC, 8'h00);
		rd(CPMC_OFS_VCO_DIV, 8'h00);
		$display("test reset done");
		wr(CPMC_OFS_PLL_MODE, 8'h00);
		chk(16'(path), 16'h1400);
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr(CPMC_OFS_PLL_MODE, {m[0], 3'h0, m, m});
			wr(CPMC_OFS_UPDATE, 8'h01);
			chk(16'(path.pll_on), 16'(m == 2'h0));
			chk(16'(path.pfd_negative), 16'(m[0]));
			chk(16'(path.cp_mode), 16'(m));
		end
		$display("test pll mode done");
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr(CPMC_OFS_DIST_SRC, {6'h00, m});
			wr(CPMC_OFS_UPDATE, 8'h01);
			chk(16'(path.src_vco), 16'(m[1]));
			chk(16'(path.src_ext_clk), 16'(!m[1]));
			chk(16'(path.div_bypass), 16'(m[0]));
		end
		rd(CPMC_OFS_DIST_SRC, 8'h03);
		$display("test source done");
		// internal vco: pll on, divider kept in the path
		wr(CPMC_OFS_PLL_MODE, 8'h0C);
		wr(CPMC_OFS_DIST_SRC, 8'h02);
		wr(CPMC_OFS_VCO_DIV, 8'h03);
		wr(CPMC_OFS_REF_EN, 8'h07);
		chk(16'(path.vco_div_sel), 16'h0000);
		wr(CPMC_OFS_UPDATE, 8'h01);
		chk(16'({path.pll_on, path.src_vco}), 16'h0003);
		chk(16'(path.div_bypass), 16'h0000);
		chk(16'(path.cp_mode), 16'(CPMC_CP_NORMAL));
		chk(16'(path.vco_div_sel), 16'h0003);
		chk(16'(path.ref_enable), 16'h0007);
		rd(CPMC_OFS_VCO_DIV, 8'h03);
		rd(CPMC_OFS_REF_EN, 8'h07);
		$display("test internal vco done");
		// external clock below the limit, divider bypassed
		wr(CPMC_OFS_PLL_MODE, 8'h01);
		wr(CPMC_OFS_DIST_SRC, 8'h01);
		wr(CPMC_OFS_UPDATE, 8'h01);
		chk(16'({path.pll_power_down, path.src_ext_clk}), 16'h0003);
		chk(16'(path.div_bypass), 16'h0001);
		// external vco below the limit needs the pll on
		wr(CPMC_OFS_PLL_MODE, 8'h0C);
		wr(CPMC_OFS_UPDATE, 8'h01);
		chk(16'({path.pll_on, path.src_ext_clk}), 16'h0003);
		chk(16'(path.div_bypass), 16'h0001);
		$display("test external path done");
		wr(CPMC_OFS_VCO_CAL, 8'h01);
		wr(CPMC_OFS_UPDATE, 8'h01);
		chk(16'({cal_start, cal_busy}), 16'h0003);
		@(posedge clock);
		#1;
		chk(16'(cal_start), 16'h0000);
		wr(CPMC_OFS_UPDATE, 8'h01);
		chk(16'(cal_start), 16'h0000);
		wr(CPMC_OFS_VCO_CAL, 8'h00);
		wr(CPMC_OFS_UPDATE, 8'h01);
		chk(16'(cal_busy), 16'h0000);
		wr(CPMC_OFS_VCO_CAL, 8'h01);
		wr(CPMC_OFS_UPDATE, 8'h01);
		chk(16'(cal_start), 16'h0001);
		rd(10'h3FF, 8'h00);
		rd(CPMC_OFS_UPDATE, 8'h00);
		$display("test calibration done");
		// reset in mid-run drops staged and active state alike
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		#1;
		chk(16'(path), 16'h1400);
		chk(16'({cal_start, cal_busy}), 16'h0000);
		rd(CPMC_OFS_VCO_CAL, 8'h00);
		rd(CPMC_OFS_VCO_DIV, 8'h00);
		wr(CPMC_OFS_VCO_CAL, 8'h01);
		wr(CPMC_OFS_UPDATE, 8'h01);
		chk(16'({cal_start, cal_busy}), 16'h0003);
		$display("test mid reset done");
		print_verdict;
	end
endmodule
